// >>> src/wdl_top.sv
`timescale 1ns/1ps
module wdl_top
	import wdl_pkg::*;
(
	input  wire logic              CLK_SYS,     // System clock, 25 MHz
	input  wire logic              RST_N,       // Synchronous reset, active low
	input  wire logic              TICK_CLK,    // Slow counting clock pin
	input  wire logic [ADDR_W-1:0] AWADDR,      // Write address
	input  wire logic              AWVALID,     // Write address valid
	output logic                   AWREADY,     // Write address ready
	input  wire logic [DATA_W-1:0] WDATA,       // Write data
	input  wire logic [3:0]        WSTRB,       // Write byte strobes
	input  wire logic              WVALID,      // Write data valid
	output logic                   WREADY,      // Write data ready
	output logic [1:0]             BRESP,       // Write response
	output logic                   BVALID,      // Write response valid
	input  wire logic              BREADY,      // Write response ready
	input  wire logic [ADDR_W-1:0] ARADDR,      // Read address
	input  wire logic              ARVALID,     // Read address valid
	output logic                   ARREADY,     // Read address ready
	output logic [DATA_W-1:0]      RDATA,       // Read data
	output logic [1:0]             RRESP,       // Read response
	output logic                   RVALID,      // Read data valid
	input  wire logic              RREADY,      // Read data ready
	output logic                   IRQ,         // Level interrupt
	output logic                   REBOOT_REQ   // System reset request
);

	// ********************************************
	// Helper functions
	// ********************************************

	// Word-aligned decode shared by both channels
	function automatic wdl_sel_type decode(input logic [ADDR_W-1:0] a);
		wdl_sel_type s;
		s = SEL_NONE;
		case ({a[ADDR_W-1:2], 2'b00})
			OFS_RELOAD:   s = SEL_RELOAD;
			OFS_COUNT:    s = SEL_COUNT;
			OFS_CTRL:     s = SEL_CTRL;
			OFS_ICLR:     s = SEL_ICLR;
			OFS_RAW:      s = SEL_RAW;
			OFS_MASKED:   s = SEL_MASKED;
			OFS_EVT_STAT: s = SEL_EVT_STAT;
			OFS_EVT_MASK: s = SEL_EVT_MASK;
			OFS_LOCK:     s = SEL_LOCK;
			default:      s = SEL_NONE;
		endcase
		return s;
	endfunction

	// Merge write data into a word under byte strobes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
	                                      input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// ********************************************
	// Declarations
	// ********************************************
	logic              awready_q;
	logic              wready_q;
	logic              arready_q;
	logic              bvalid_q;
	logic              rvalid_q;
	logic [1:0]        bresp_q;
	logic [1:0]        rresp_q;
	logic [31:0]       rdata_q;
	logic              aw_full_q;
	logic              w_full_q;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [31:0]       w_data_q;
	logic [3:0]        w_strb_q;
	logic              aw_full_d;
	logic              w_full_d;
	logic              bvalid_d;
	logic              rvalid_d;
	logic              aw_take;
	logic              w_take;
	logic              ar_take;
	logic              wr_do;
	wdl_sel_type       wr_sel;
	wdl_sel_type       rd_sel;
	logic              tclk_s1_q;
	logic              tclk_s2_q;
	logic              tclk_s3_q;
	logic              tick;
	logic [31:0]       reload_value_q;
	logic [31:0]       count_q;
	logic [1:0]        control_bits_q;
	logic              raw_irq_q;
	logic              locked_q;
	logic [EVT_W-1:0]  evt_q;
	logic [EVT_W-1:0]  evt_mask_q;
	logic              irq_q;
	logic              reboot_q;
	logic              wr_open;
	logic              reload_wr;
	logic              ctrl_wr;
	logic              iclr_wr;
	logic [31:0]       ctrl_new;
	logic              start_run;
	logic              at_zero;
	logic              zero_evt;
	logic              reboot_evt;
	logic [31:0]       evt_clr;
	logic [31:0]       strobed_wdata;
	logic [31:0]       mask_new;

	// ********************************************
	// AXI4-Lite write channels
	// ********************************************

	// Address and data accepted in either order
	assign aw_take   = AWVALID & awready_q;
	assign w_take    = WVALID & wready_q;
	assign wr_do     = aw_full_q & w_full_q & ~bvalid_q;
	assign aw_full_d = (aw_full_q | aw_take) & ~wr_do;
	assign w_full_d  = (w_full_q | w_take) & ~wr_do;
	assign bvalid_d  = wr_do | (bvalid_q & ~BREADY);

	// Decode the parked address, not the live bus
	assign wr_sel    = decode(aw_addr_q);

	// Handshake state; ready drops while a beat is parked
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			aw_full_q <= 1'b0;
			w_full_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
		end else begin
			aw_full_q <= aw_full_d;
			w_full_q  <= w_full_d;
			bvalid_q  <= bvalid_d;
			awready_q <= ~aw_full_d & ~bvalid_d;
			wready_q  <= ~w_full_d & ~bvalid_d;
			if (wr_do) begin
				bresp_q <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
			end
		end
	end

	// Payload capture
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			aw_addr_q <= '0;
			w_data_q  <= '0;
			w_strb_q  <= '0;
		end else begin
			if (aw_take) begin
				aw_addr_q <= AWADDR;
			end
			if (w_take) begin
				w_data_q <= WDATA;
				w_strb_q <= WSTRB;
			end
		end
	end

	// ********************************************
	// AXI4-Lite read channel
	// ********************************************
	// One read in flight; ready waits for the answer to drain
	assign ar_take  = ARVALID & arready_q;
	assign rvalid_d = ar_take | (rvalid_q & ~RREADY);
	assign rd_sel   = decode(ARADDR);

	// Read data sampled at acceptance, one cycle answer
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= '0;
			rresp_q   <= RESP_OKAY;
		end else begin
			rvalid_q  <= rvalid_d;
			arready_q <= ~rvalid_d;
			if (ar_take) begin
				rresp_q <= RESP_OKAY;
				case (rd_sel)
					SEL_RELOAD:   rdata_q <= reload_value_q;
					SEL_COUNT:    rdata_q <= count_q;
					SEL_CTRL:     rdata_q <= {30'h0, control_bits_q};
					SEL_ICLR:     rdata_q <= 32'h0;
					SEL_RAW:      rdata_q <= {31'h0, raw_irq_q};
					SEL_MASKED:   rdata_q <= {31'h0, raw_irq_q & control_bits_q[CTRL_IRQ_ON]};
					SEL_EVT_STAT: rdata_q <= {30'h0, evt_q};
					SEL_EVT_MASK: rdata_q <= {30'h0, evt_mask_q};
					SEL_LOCK:     rdata_q <= {31'h0, locked_q};
					default: begin
						rdata_q <= 32'h0;
						rresp_q <= RESP_SLVERR;
					end
				endcase
			end
		end
	end

	// ********************************************
	// Write effects and lock
	// ********************************************

	// Lock register itself always writable; gates reload, control and clear writes, not event status or mask
	assign wr_open   = wr_do & ~locked_q;
	assign reload_wr = wr_open & (wr_sel == SEL_RELOAD);
	assign ctrl_wr   = wr_open & (wr_sel == SEL_CTRL);
	assign iclr_wr   = wr_open & (wr_sel == SEL_ICLR);
	assign ctrl_new  = merge({30'h0, control_bits_q}, w_data_q, w_strb_q);
	assign start_run = ctrl_wr & ctrl_new[CTRL_IRQ_ON] & ~control_bits_q[CTRL_IRQ_ON];
	assign evt_clr   = (wr_do & (wr_sel == SEL_EVT_STAT)) ? strobed_wdata : 32'h0;

	// Strobed views of the write word; lanes left out read as zero, or keep the old mask in mask_new
	assign strobed_wdata = merge(32'h0, w_data_q, w_strb_q);
	assign mask_new      = merge({30'h0, evt_mask_q}, w_data_q, w_strb_q);

	// Lock state: key opens, anything else closes
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			locked_q <= 1'b0;
		end else if (wr_do && wr_sel == SEL_LOCK) begin
			locked_q <= (strobed_wdata != UNLOCK_KEY);
		end
	end

	// Load value and control bits
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			reload_value_q <= RST_RELOAD;
			control_bits_q <= RST_CTRL;
		end else begin
			if (reload_wr) begin
				reload_value_q <= merge(reload_value_q, w_data_q, w_strb_q);
			end
			if (ctrl_wr) begin
				control_bits_q <= ctrl_new[1:0];
			end
		end
	end

	// ********************************************
	// Slow tick synchroniser
	// ********************************************

	// Tick pin is asynchronous; edge taken after two flops
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			tclk_s1_q <= 1'b0;
			tclk_s2_q <= 1'b0;
			tclk_s3_q <= 1'b0;
		end else begin
			tclk_s1_q <= TICK_CLK;
			tclk_s2_q <= tclk_s1_q;
			tclk_s3_q <= tclk_s2_q;
		end
	end
	// Edge taken from the second and third flops, never the first
	assign tick = tclk_s2_q & ~tclk_s3_q;

	// ********************************************
	// Down-counter
	// ********************************************
	// Zero counts only on a tick while running
	assign at_zero    = control_bits_q[CTRL_IRQ_ON] & tick & (count_q == 32'h0);
	assign zero_evt   = at_zero;
	assign reboot_evt = at_zero & raw_irq_q & control_bits_q[CTRL_RBT_ON];

	// Reload beats decrement: a reload this cycle discards the tick
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			count_q <= RST_COUNT;
		end else if (reload_wr) begin
			count_q <= merge(reload_value_q, w_data_q, w_strb_q);
		end else if (iclr_wr || start_run) begin
			count_q <= reload_value_q;
		end else if (control_bits_q[CTRL_IRQ_ON] && tick) begin
			if (count_q == 32'h0) begin
				count_q <= reload_value_q;
			end else begin
				count_q <= count_q - 32'h1;
			end
		end
	end

	// Raw status: a zero in the clear cycle still sets it
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			raw_irq_q <= 1'b0;
		end else begin
			raw_irq_q <= zero_evt | (raw_irq_q & ~iclr_wr);
		end
	end

	// Reset request sticks; only system reset releases it
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			reboot_q <= 1'b0;
		end else if (reboot_evt) begin
			reboot_q <= 1'b1;
		end
	end

	// ********************************************
	// Interrupt status, mask and output
	// ********************************************

	// Sticky events, write one to clear, set wins
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			evt_q      <= '0;
			evt_mask_q <= '0;
		end else begin
			evt_q[EVT_ZERO] <= zero_evt | (evt_q[EVT_ZERO] & ~evt_clr[EVT_ZERO]);
			evt_q[EVT_RBT]  <= reboot_evt | (evt_q[EVT_RBT] & ~evt_clr[EVT_RBT]);
			if (wr_do && wr_sel == SEL_EVT_MASK) begin
				evt_mask_q <= mask_new[EVT_W-1:0];
			end
		end
	end

	// Level interrupt, registered
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(evt_q & evt_mask_q);
		end
	end

	// ********************************************
	// Outputs
	// ********************************************
	// Bus handshake and answer
	assign AWREADY    = awready_q;
	assign WREADY     = wready_q;
	assign BVALID     = bvalid_q;
	assign BRESP      = bresp_q;
	assign ARREADY    = arready_q;
	assign RVALID     = rvalid_q;
	assign RDATA      = rdata_q;
	assign RRESP      = rresp_q;

	// Event outputs, clean registered levels
	assign IRQ        = irq_q;
	assign REBOOT_REQ = reboot_q;

endmodule // wdl_top

// >>> src/wdl_pkg.sv
package wdl_pkg;

	// ********************************************
	// Bus geometry
	// ********************************************
	localparam int          ADDR_W        = 12;
	localparam int          DATA_W        = 32;

	// ********************************************
	// Register byte offsets
	// ********************************************
	localparam logic [11:0] OFS_RELOAD    = 12'h000;
	localparam logic [11:0] OFS_COUNT     = 12'h004;
	localparam logic [11:0] OFS_CTRL      = 12'h008;
	localparam logic [11:0] OFS_ICLR      = 12'h00c;
	localparam logic [11:0] OFS_RAW       = 12'h010;
	localparam logic [11:0] OFS_MASKED    = 12'h014;
	localparam logic [11:0] OFS_EVT_STAT  = 12'h018;
	localparam logic [11:0] OFS_EVT_MASK  = 12'h01c;
	localparam logic [11:0] OFS_LOCK      = 12'hc00;

	// ********************************************
	// Fields and reset values
	// ********************************************
	localparam int          CTRL_IRQ_ON   = 0;
	localparam int          CTRL_RBT_ON   = 1;
	localparam int          EVT_ZERO      = 0;
	localparam int          EVT_RBT       = 1;
	localparam int          EVT_W         = 2;
	localparam logic [31:0] RST_RELOAD    = 32'h0fffffff;
	localparam logic [31:0] RST_COUNT     = 32'h0fffffff;
	localparam logic [1:0]  RST_CTRL      = 2'h0;
	localparam logic [31:0] UNLOCK_KEY    = 32'h1acce551;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	// ********************************************
	// Timing
	// ********************************************
	localparam int          SYS_CLK_HZ    = 25000000;
	localparam int          TICK_HZ       = 32768;
	localparam int          SYS_PER_TICK  = SYS_CLK_HZ / TICK_HZ;

	// Register selector from address decode
	typedef enum logic [3:0] {
		SEL_RELOAD,
		SEL_COUNT,
		SEL_CTRL,
		SEL_ICLR,
		SEL_RAW,
		SEL_MASKED,
		SEL_EVT_STAT,
		SEL_EVT_MASK,
		SEL_LOCK,
		SEL_NONE
	} wdl_sel_type;

endpackage

// >>> tb/wdl_monitor.sv
`timescale 1ns/1ps
module wdl_monitor
	import wdl_pkg::*;
(
	input wire logic              CLK_SYS,    // Clock
	input wire logic              RST_N,      // Sync reset
	input wire logic              TICK_CLK,   // Tick pin
	input wire logic              AWVALID,    // AW valid
	input wire logic              AWREADY,    // AW ready
	input wire logic              WVALID,     // W valid
	input wire logic              WREADY,     // W ready
	input wire logic              BVALID,     // B valid
	input wire logic [ADDR_W-1:0] ARADDR,     // Read address
	input wire logic              ARVALID,    // AR valid
	input wire logic              ARREADY,    // AR ready
	input wire logic [DATA_W-1:0] RDATA,      // Read data
	input wire logic              RVALID,     // R valid
	input wire logic              REBOOT_REQ  // Reset request
);
	// ********
	// Helpers
	// ********
	logic [7:0]        tick_hist_q;
	logic [ADDR_W-1:0] rd_addr_q;
	logic              tick_recent;
	// Pin history, so a reboot can be traced to a tick
	always_ff @(posedge CLK_SYS) tick_hist_q <= {tick_hist_q[6:0], TICK_CLK};
	// Address of the read in flight
	always_ff @(posedge CLK_SYS) if (ARVALID && ARREADY) rd_addr_q <= ARADDR;
	// Rising pin edge inside the window
	assign tick_recent = |(tick_hist_q[6:0] & ~tick_hist_q[7:1]);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	// ********
	// Checks
	// ********
	reboot_held_a: assert property (REBOOT_REQ |=> REBOOT_REQ)
		else $error("reset request dropped");
	reboot_cause_a: assert property ($rose(REBOOT_REQ) |-> tick_recent)
		else $error("reset request without a tick");
	clear_reads_zero_a: assert property (RVALID && rd_addr_q == OFS_ICLR |-> RDATA == 32'h0)
		else $error("clear register read not zero");
	raw_upper_zero_a: assert property (RVALID && rd_addr_q == OFS_RAW |-> RDATA[31:1] == 31'h0)
		else $error("raw status upper bits set");
	masked_upper_zero_a: assert property (RVALID && rd_addr_q == OFS_MASKED |-> RDATA[31:1] == 31'h0)
		else $error("masked status upper bits set");
	lock_one_bit_a: assert property (RVALID && rd_addr_q == OFS_LOCK |-> RDATA[31:1] == 31'h0)
		else $error("lock status upper bits set");
	read_answer_a: assert property (ARVALID && ARREADY |=> RVALID)
		else $error("read answer late");
	write_answer_a: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##[1:2] BVALID)
		else $error("write answer late");
	aw_refused_a: assert property (AWVALID && AWREADY |=> !AWREADY)
		else $error("second write address taken");
endmodule // wdl_monitor
bind wdl_top wdl_monitor wdl_monitor_inst (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .TICK_CLK(TICK_CLK),
	.AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID),
	.ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RVALID(RVALID),
	.REBOOT_REQ(REBOOT_REQ));

// >>> tb/tb.sv
`timescale 1ns/1ps
module tb
	import wdl_pkg::*;
;
	typedef struct {logic [11:0] a; logic [31:0] d; logic [1:0] r;} wdl_row_type;
	logic              CLK_SYS, RST_N, TICK_CLK, AWVALID, WVALID, BREADY, ARVALID, RREADY;
	logic              AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ, REBOOT_REQ;
	logic [ADDR_W-1:0] AWADDR, ARADDR;
	logic [DATA_W-1:0] WDATA, RDATA, rd_data;
	logic [3:0]        WSTRB;
	logic [1:0]        BRESP, RRESP, rd_resp, wr_resp;
	int                n_fail, check_count;
	// Reset contents; the last row is an unmapped place
	wdl_row_type       rows [10] = '{'{OFS_RELOAD, RST_RELOAD, RESP_OKAY}, '{OFS_COUNT, RST_COUNT, RESP_OKAY},
		'{OFS_CTRL, 32'h0, RESP_OKAY}, '{OFS_ICLR, 32'h0, RESP_OKAY}, '{OFS_RAW, 32'h0, RESP_OKAY},
		'{OFS_MASKED, 32'h0, RESP_OKAY}, '{OFS_EVT_STAT, 32'h0, RESP_OKAY}, '{OFS_EVT_MASK, 32'h0, RESP_OKAY},
		'{OFS_LOCK, 32'h0, RESP_OKAY}, '{12'h020, 32'h0, RESP_SLVERR}};

	wdl_top wdl_top_inst (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .TICK_CLK(TICK_CLK), .AWADDR(AWADDR),
		.AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
		.WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
		.ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
		.RREADY(RREADY), .IRQ(IRQ), .REBOOT_REQ(REBOOT_REQ));

	// ********
	// Tasks
	// ********
	task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk1(input string nm, input logic e, input logic g);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %s expected %b seen %b", nm, e, g);
		end
	endtask
	// Address and data offered together, each dropped once taken
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		AWADDR <= a;
		WDATA <= d;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		do begin
			@(posedge CLK_SYS);
			if (AWREADY) AWVALID <= 1'b0;
			if (WREADY) WVALID <= 1'b0;
		end while (BVALID !== 1'b1);
		wr_resp = BRESP;
		BREADY <= 1'b0;
		// Idle edge, so a next call never re-drives a ready in this step
		@(posedge CLK_SYS);
	endtask
	task automatic rd(input logic [11:0] a);
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		do begin
			@(posedge CLK_SYS);
			if (ARREADY) ARVALID <= 1'b0;
		end while (RVALID !== 1'b1);
		rd_data = RDATA;
		rd_resp = RRESP;
		RREADY <= 1'b0;
		@(posedge CLK_SYS);
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] e, input string nm);
		rd(a);
		chk32(nm, e, rd_data);
	endtask
	// Slow ticks; 8 cycles per half period leaves room for the synchroniser
	task automatic ticks(input int k);
		repeat (k) begin
			TICK_CLK <= 1'b1;
			repeat (8) @(posedge CLK_SYS);
			TICK_CLK <= 1'b0;
			repeat (8) @(posedge CLK_SYS);
		end
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ********
	// Clock, watchdog, tests
	// ********
	initial begin
		CLK_SYS = 1'b0;
		forever #20 CLK_SYS = ~CLK_SYS;
	end
	// Tests need about 500 cycles
	initial begin
		repeat (8000) @(posedge CLK_SYS);
		n_fail++;
		summarize;
	end
	initial begin
		{RST_N, TICK_CLK, AWVALID, WVALID, BREADY, ARVALID, RREADY} <= 7'h0;
		AWADDR <= 12'h0;
		ARADDR <= 12'h0;
		WDATA <= 32'h0;
		WSTRB <= 4'hf;
		repeat (12) @(posedge CLK_SYS);
		RST_N <= 1'b1;
		@(posedge CLK_SYS);
		foreach (rows[i]) begin
			rchk(rows[i].a, rows[i].d, "reset read");
			chk32("reset resp", {30'h0, rows[i].r}, {30'h0, rd_resp});
		end
		$display("test reset values done");
		wr(OFS_RELOAD, 32'h3);
		wr(OFS_CTRL, 32'h1);
		rchk(OFS_COUNT, 32'h3, "count start");
		ticks(1);
		rchk(OFS_COUNT, 32'h2, "count step");
		ticks(2);
		rchk(OFS_RAW, 32'h0, "raw early");
		ticks(1);
		rchk(OFS_RAW, 32'h1, "raw at zero");
		rchk(OFS_COUNT, 32'h3, "count reload");
		rchk(OFS_MASKED, 32'h1, "masked set");
		chk1("irq masked", 1'b0, IRQ);
		wr(OFS_EVT_MASK, 32'h1);
		repeat (2) @(posedge CLK_SYS);
		chk1("irq on", 1'b1, IRQ);
		wr(OFS_EVT_STAT, 32'h1);
		repeat (2) @(posedge CLK_SYS);
		chk1("irq cleared", 1'b0, IRQ);
		ticks(4);
		chk1("reboot off", 1'b0, REBOOT_REQ);
		$display("test counting done");
		ticks(1);
		wr(OFS_ICLR, 32'h0);
		rchk(OFS_RAW, 32'h0, "raw cleared");
		rchk(OFS_COUNT, 32'h3, "clear reload");
		ticks(1);
		wr(OFS_CTRL, 32'h0);
		ticks(1);
		rchk(OFS_COUNT, 32'h2, "count frozen");
		wr(OFS_CTRL, 32'h1);
		rchk(OFS_COUNT, 32'h3, "count restart");
		wr(OFS_COUNT, 32'h5);
		chk32("count write resp", {30'h0, RESP_OKAY}, {30'h0, wr_resp});
		wr(OFS_RAW, 32'h1);
		wr(OFS_MASKED, 32'h1);
		wr(12'h020, 32'h1);
		chk32("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, wr_resp});
		rchk(OFS_COUNT, 32'h3, "count kept");
		rchk(OFS_RAW, 32'h0, "raw kept");
		rchk(OFS_MASKED, 32'h0, "masked kept");
		$display("test clear and enable done");
		wr(OFS_LOCK, 32'h0);
		rchk(OFS_LOCK, 32'h1, "locked");
		wr(OFS_RELOAD, 32'h9);
		rchk(OFS_RELOAD, 32'h3, "load blocked");
		wr(OFS_LOCK, UNLOCK_KEY);
		rchk(OFS_LOCK, 32'h0, "unlocked");
		wr(OFS_RELOAD, 32'h1);
		rchk(OFS_RELOAD, 32'h1, "load open");
		rchk(OFS_COUNT, 32'h1, "load restart");
		$display("test lock done");
		wr(OFS_CTRL, 32'h3);
		ticks(2);
		chk1("reboot early", 1'b0, REBOOT_REQ);
		ticks(2);
		chk1("reboot on", 1'b1, REBOOT_REQ);
		repeat (20) @(posedge CLK_SYS);
		chk1("reboot held", 1'b1, REBOOT_REQ);
		rchk(OFS_EVT_STAT, 32'h3, "events latched");
		RST_N <= 1'b0;
		repeat (12) @(posedge CLK_SYS);
		RST_N <= 1'b1;
		@(posedge CLK_SYS);
		chk1("reboot reset", 1'b0, REBOOT_REQ);
		rchk(OFS_COUNT, RST_COUNT, "count reset");
		$display("test reboot done");
		summarize;
	end
endmodule // tb
